// file: rtl/dbd_ctrl.sv
// Blanking and dimming control of a four-digit dot-matrix display.
`timescale 1ns/1ps
`default_nettype none
module dbd_ctrl (
  input wire logic mclk_in,                     // System clock, 125 MHz.
  input wire logic nrst_in,                     // Synchronous reset, active low.
  input wire logic wipe_n_in,                   // Clear pin, active low.
  input wire logic ext_blank_n_in,              // Blank pin, active low.
  input wire logic cursor_show_sel_in,          // Cursor display select pin.
  input wire logic wr_n_in,                     // Write strobe pin, active low.
  input wire logic ce_n_in,                     // Combined chip enable, active low.
  input wire logic ascii_sel_in,                // High selects character RAM.
  input wire logic [1:0] addr_in,               // Digit address.
  input wire logic [6:0] data_in,               // Write data.
  output logic [dbd_pkg::DIGITS-1:0] row_en_out,   // Row driver enable per digit.
  output logic [dbd_pkg::DIGITS-1:0] cursor_out    // Digit shows full cursor block.
);
  // Pin synchronisers.
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic blank_n;
  logic wipe_n;
  logic cursor_show_sel;
  logic wr_n;
  logic ce_n;
  logic csel;
  logic wr_d_r;
  logic [1:0] addr_s1_r;
  logic [1:0] addr_s2_r;
  logic [6:0] data_s1_r;
  logic [6:0] data_s2_r;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      s1_r <= 6'h3f;
      s2_r <= 6'h3f;
      addr_s1_r <= 2'h0;
      addr_s2_r <= 2'h0;
      data_s1_r <= 7'h00;
      data_s2_r <= 7'h00;
      wr_d_r <= 1'b1;
    end else begin
      s1_r <= {ext_blank_n_in, wipe_n_in, cursor_show_sel_in, wr_n_in, ce_n_in, ascii_sel_in};
      s2_r <= s1_r;
      addr_s1_r <= addr_in;
      addr_s2_r <= addr_s1_r;
      data_s1_r <= data_in;
      data_s2_r <= data_s1_r;
      wr_d_r <= wr_n;
    end
  end

  assign {blank_n, wipe_n, cursor_show_sel, wr_n, ce_n, csel} = s2_r;

  // Control register and attribute bits.
  dbd_pkg::dbd_ctl_s ctl_r;
  dbd_pkg::dbd_ctl_s ctl_nxt;
  logic [dbd_pkg::DIGITS-1:0] ovr_r;
  logic [dbd_pkg::DIGITS-1:0] ovr_nxt;
  logic [dbd_pkg::DIGITS-1:0] cur_r;
  logic [dbd_pkg::DIGITS-1:0] cur_nxt;
  logic wr_rise;

  // Data is latched on the rising edge of the write strobe.
  assign wr_rise = wr_n && !wr_d_r && !ce_n && !csel;

  always_comb begin
    ctl_nxt = ctl_r;
    ovr_nxt = ovr_r;
    cur_nxt = cur_r;
    if (!wipe_n) begin
      ctl_nxt = dbd_pkg::CTL_RESET;
      ovr_nxt = dbd_pkg::ATT_RESET;
      cur_nxt = dbd_pkg::ATT_RESET;
    end else if (wr_rise) begin
      ctl_nxt.compat = data_s2_r[dbd_pkg::CTL_COMPAT_POS];
      ctl_nxt.bright = data_s2_r[dbd_pkg::CTL_BRIGHT_LSB +: 3];
      ctl_nxt.gblank = data_s2_r[dbd_pkg::CTL_BLANK_POS];
      ovr_nxt[addr_s2_r] = data_s2_r[dbd_pkg::ATT_OVR_POS];
      cur_nxt[addr_s2_r] = data_s2_r[dbd_pkg::ATT_CURSOR_POS];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ctl_r <= dbd_pkg::CTL_RESET;
      ovr_r <= dbd_pkg::ATT_RESET;
      cur_r <= dbd_pkg::ATT_RESET;
    end else begin
      ctl_r <= ctl_nxt;
      ovr_r <= ovr_nxt;
      cur_r <= cur_nxt;
    end
  end

  // Internal modulation.
  logic pwm_on;
  logic pwm_half;
  logic int_on;

  dbd_pwm u_pwm (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .code_in(ctl_r.bright),
    .on_out(pwm_on),
    .half_out(pwm_half)
  );

  assign int_on = ctl_r.compat ? 1'b1 : pwm_on;

  // Per-digit enable.
  logic [dbd_pkg::DIGITS-1:0] row_en_nxt;
  logic [dbd_pkg::DIGITS-1:0] cursor_nxt;
  logic [dbd_pkg::DIGITS-1:0] row_en_r;
  logic [dbd_pkg::DIGITS-1:0] cursor_r;
  logic blank_any;

  assign blank_any = !blank_n || ctl_r.gblank;

  // Two address bits reach exactly four digits, so no other count can be served.
  if (dbd_pkg::DIGITS != 4) begin : g_digits_check
    $error("digit count must be four");
  end

  genvar g;
  generate
    for (g = 0; g < dbd_pkg::DIGITS; g++) begin : g_dig
      always_comb begin
        if (ctl_r.compat) begin
          row_en_nxt[g] = blank_n;
        end else if (ovr_r[g]) begin
          row_en_nxt[g] = int_on;
        end else begin
          row_en_nxt[g] = !blank_any && int_on;
        end
        cursor_nxt[g] = cursor_show_sel && cur_r[g];
        if (cursor_nxt[g] && !pwm_half) begin
          row_en_nxt[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      row_en_r <= '0;
      cursor_r <= '0;
    end else begin
      row_en_r <= row_en_nxt;
      cursor_r <= cursor_nxt;
    end
  end

  assign row_en_out = row_en_r;
  assign cursor_out = cursor_r;

  AST_COMPAT_PIN: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    ctl_r.compat && !cursor_nxt[0] |=> row_en_r[0] == $past(blank_n))
    else $error("compat mode digit does not follow blank pin");
  AST_GBLANK: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !ctl_r.compat && ctl_r.gblank && !ovr_r[1] |=> !row_en_r[1])
    else $error("global blank did not blank digit");
  AST_PIN_BLANK: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !blank_n && !ovr_r[2] |=> !row_en_r[2])
    else $error("blank pin low did not blank digit");
  AST_OVERRIDE: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !ctl_r.compat && ovr_r[3] && !cursor_nxt[3] && pwm_on |=> row_en_r[3])
    else $error("overridden digit was blanked");
  AST_NO_DIM_COMPAT: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    ctl_r.compat && blank_n && !cursor_nxt[0] |=> row_en_r[0])
    else $error("internal dimming active in compat mode");
  AST_WIPE: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !wipe_n |=> ctl_r == dbd_pkg::CTL_RESET && ovr_r == 4'h0 && cur_r == 4'h0)
    else $error("wipe did not clear control bits");
  AST_CURSOR: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    cursor_show_sel && cur_r[1] |=> cursor_r[1])
    else $error("cursor not shown");
  AST_PWM_GATE: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !ctl_r.compat && !pwm_on |=> row_en_r == 4'h0)
    else $error("digit lit during modulation off phase");
  AST_GBLANK_ALL: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !ctl_r.compat && ctl_r.gblank |=> (row_en_r & ~$past(ovr_r)) == 4'h0)
    else $error("global blank left a plain digit lit");
  AST_PIN_ALL: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !ctl_r.compat && !blank_n |=> (row_en_r & ~$past(ovr_r)) == 4'h0)
    else $error("plain digit lit while blank pin low");
  AST_FLASH_KEEP: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !ctl_r.compat && ovr_r[2] && !blank_n && pwm_on && !cursor_nxt[2] |=> row_en_r[2])
    else $error("overridden digit went dark with blank pin low");
  AST_DIM_EXTENDED: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !ctl_r.compat && ovr_r[3] && !pwm_on |=> !row_en_r[3])
    else $error("overridden digit lit during modulation off phase");
  AST_COMPAT_ALL: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    ctl_r.compat && cursor_nxt == 4'h0 |=> row_en_r == {dbd_pkg::DIGITS{$past(blank_n)}})
    else $error("compat mode digits do not follow blank pin");
  AST_COMPAT_FIELD: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    wr_rise && wipe_n |=> ctl_r.compat == $past(data_s2_r[dbd_pkg::CTL_COMPAT_POS]))
    else $error("compat bit not taken from write data");
  AST_BRIGHT_FIELD: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    wr_rise && wipe_n |=> ctl_r.bright == $past(data_s2_r[dbd_pkg::CTL_BRIGHT_LSB +: 3]))
    else $error("brightness code not taken from write data");
  AST_CURSOR_HALF: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    cursor_nxt[2] && !pwm_half |=> !row_en_r[2])
    else $error("cursor digit lit in its dark half phase");
  AST_CURSOR_OFF: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !cursor_show_sel |=> cursor_r == 4'h0)
    else $error("cursor shown with cursor select low");
endmodule // dbd_ctrl
`default_nettype wire

// file: rtl/dbd_pkg.sv
// Package with constants and carrier types of the blank and dim control block.
`default_nettype none
package dbd_pkg;
  localparam int DIGITS = 4;
  // Control register field positions within the written data word.
  localparam int CTL_BLANK_POS = 2;
  localparam int CTL_BRIGHT_LSB = 3;
  localparam int CTL_COMPAT_POS = 6;
  // Attribute field positions within the written data word.
  localparam int ATT_CURSOR_POS = 0;
  localparam int ATT_OVR_POS = 1;
  // Reset values after wipe.
  localparam logic [4:0] CTL_RESET = 5'h00;
  localparam logic [3:0] ATT_RESET = 4'h0;
  // Modulation frame and per-code on-cycles (100,60,40,27,17,10,7,3 percent of 100 steps).
  localparam int PWM_STEPS = 100;
  localparam logic [6:0] PWM_LAST = 7'h63;
  localparam logic [6:0] DUTY_0 = 7'h64;
  localparam logic [6:0] DUTY_1 = 7'h3c;
  localparam logic [6:0] DUTY_2 = 7'h28;
  localparam logic [6:0] DUTY_3 = 7'h1b;
  localparam logic [6:0] DUTY_4 = 7'h11;
  localparam logic [6:0] DUTY_5 = 7'h0a;
  localparam logic [6:0] DUTY_6 = 7'h07;
  localparam logic [6:0] DUTY_7 = 7'h03;
  // Shortest clear pulse a host should give, and its length in clock cycles.
  localparam int WIPE_NS = 10000;
  localparam int CLK_NS = 8;
  localparam int WIPE_CYC = (WIPE_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic compat;
    logic [2:0] bright;
    logic gblank;
  } dbd_ctl_s;

  typedef struct packed {
    logic wr;
    logic sel_ctl;
    logic [1:0] addr;
    logic [6:0] data;
  } dbd_wr_s;
endpackage
`default_nettype wire

// file: rtl/dbd_pwm.sv
// Internal brightness modulator that turns a three-bit code into an enable.
`timescale 1ns/1ps
`default_nettype none
module dbd_pwm (
  input wire logic mclk_in,        // System clock.
  input wire logic nrst_in,        // Synchronous reset, active low.
  input wire logic [2:0] code_in,  // Brightness code, 0 brightest.
  output logic on_out,             // Modulated enable.
  output logic half_out            // Half-duty phase for the cursor.
);
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic on_r;
  logic on_nxt;
  logic [6:0] duty;

  always_comb begin
    case (code_in)
      3'h0: duty = dbd_pkg::DUTY_0;
      3'h1: duty = dbd_pkg::DUTY_1;
      3'h2: duty = dbd_pkg::DUTY_2;
      3'h3: duty = dbd_pkg::DUTY_3;
      3'h4: duty = dbd_pkg::DUTY_4;
      3'h5: duty = dbd_pkg::DUTY_5;
      3'h6: duty = dbd_pkg::DUTY_6;
      default: duty = dbd_pkg::DUTY_7;
    endcase
    cnt_nxt = (cnt_r == dbd_pkg::PWM_LAST) ? 7'h00 : cnt_r + 7'h01;
    on_nxt = cnt_nxt < duty;
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      cnt_r <= 7'h00;
      on_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      on_r <= on_nxt;
    end
  end

  assign on_out = on_r;
  assign half_out = cnt_r[0];

  AST_DUTY_MAX: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (code_in == 3'h0) && $stable(code_in) && $past(nrst_in) |-> on_r)
    else $error("code zero must keep the enable on");
endmodule // dbd_pwm
`default_nettype wire

// file: bench/dbd_host.sv
// Host processor model driving the display write port and control pins.
`timescale 1ns/1ps
`default_nettype none
module dbd_host (
  input wire logic mclk_in,       // System clock.
  output logic wipe_n_out,        // Clear pin, active low.
  output logic blank_n_out,       // Blank pin, active low.
  output logic cue_out,           // Cursor display select.
  output logic wr_n_out,          // Write strobe, active low.
  output logic ce_n_out,          // Chip enable, active low.
  output logic asel_out,          // Character RAM select.
  output logic [1:0] addr_out,    // Digit address.
  output logic [6:0] data_out     // Write data.
);
  initial begin
    wipe_n_out = 1'b1;
    blank_n_out = 1'b1;
    cue_out = 1'b0;
    wr_n_out = 1'b1;
    ce_n_out = 1'b1;
    asel_out = 1'b0;
    addr_out = 2'h0;
    data_out = 7'h00;
  end
  // Strobe held low then high four cycles each so the synchronisers see both levels.
  task automatic wr(input logic [1:0] a, input logic [6:0] d);
    @(posedge mclk_in);
    #1;
    ce_n_out = 1'b0;
    addr_out = a;
    data_out = d;
    wr_n_out = 1'b0;
    repeat (4) @(posedge mclk_in);
    #1;
    wr_n_out = 1'b1;
    repeat (4) @(posedge mclk_in);
    #1;
    ce_n_out = 1'b1;
    addr_out = ~a;
    data_out = ~d;
  endtask
  // A square wave on blank_n far faster than 10 kHz dims without flicker.
  task automatic pins(input logic b, input logic c, input logic w);
    @(posedge mclk_in);
    #1;
    blank_n_out = b;
    cue_out = c;
    wipe_n_out = w;
  endtask
endmodule // dbd_host
`default_nettype wire

// file: bench/display_blank_dim_control_tb_top.sv
// Self-checking bench of the blank and dim control block.
`timescale 1ns/1ps
`default_nettype none
module display_blank_dim_control_tb_top;
  logic mclk_in, nrst_in, wipe_n, blank_n, cursor_show_sel, wr_n, ce_n, asel;
  logic [1:0] addr;
  logic [6:0] data;
  logic [3:0] row_en, cur;
  logic [7:0] hits [4];
  localparam logic [7:0] DUTY [8] = '{8'h64, 8'h3c, 8'h28, 8'h1b, 8'h11, 8'h0a, 8'h07, 8'h03};
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  dbd_host i_host (.mclk_in(mclk_in), .wipe_n_out(wipe_n), .blank_n_out(blank_n),
    .cue_out(cursor_show_sel), .wr_n_out(wr_n), .ce_n_out(ce_n), .asel_out(asel), .addr_out(addr),
    .data_out(data));
  dbd_ctrl i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .wipe_n_in(wipe_n),
    .ext_blank_n_in(blank_n), .cursor_show_sel_in(cursor_show_sel), .wr_n_in(wr_n), .ce_n_in(ce_n),
    .ascii_sel_in(asel), .addr_in(addr), .data_in(data), .row_en_out(row_en),
    .cursor_out(cur));
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts lit cycles of every digit over one 100-cycle window.
  task automatic count100();
    for (int d = 0; d < 4; d++) hits[d] = 8'h00;
    repeat (100) begin
      @(posedge mclk_in);
      #2;
      for (int d = 0; d < 4; d++) hits[d] = hits[d] + {7'h00, row_en[d]};
    end
  endtask
  task automatic setup(input logic [2:0] code, input logic gb, input logic cmp,
    input logic [3:0] ovr, input logic [3:0] cr);
    for (int a = 0; a < 4; a++) i_host.wr(a[1:0], {cmp, code, gb, ovr[a], cr[a]});
    repeat (6) @(posedge mclk_in);
  endtask
  task automatic t_duty();
    for (int c = 0; c < 8; c++) begin
      setup(c[2:0], 1'b0, 1'b0, 4'h0, 4'h0);
      count100();
      chk(hits[3], DUTY[c]);
    end
  endtask
  task automatic t_gblank();
    setup(3'h1, 1'b1, 1'b0, 4'h2, 4'h0);
    count100();
    chk(hits[0], 8'h00);
    chk(hits[1], 8'h3c);
  endtask
  task automatic t_pin();
    setup(3'h0, 1'b0, 1'b0, 4'h4, 4'h0);
    fork
      repeat (12) begin
        repeat (9) @(posedge mclk_in);
        i_host.pins(~blank_n, 1'b0, 1'b1);
      end
      begin
        repeat (20) @(posedge mclk_in);
        count100();
      end
    join
    chk(hits[0], 8'h32);
    chk(hits[2], 8'h64);
  endtask
  task automatic t_compat();
    setup(3'h7, 1'b1, 1'b1, 4'h1, 4'h0);
    count100();
    for (int d = 0; d < 4; d++) chk(hits[d], 8'h64);
    i_host.pins(1'b0, 1'b0, 1'b1);
    repeat (6) @(posedge mclk_in);
    count100();
    chk(hits[0], 8'h00);
    i_host.pins(1'b1, 1'b1, 1'b1);
  endtask
  task automatic t_cursor();
    setup(3'h0, 1'b0, 1'b1, 4'h0, 4'h4);
    repeat (6) @(posedge mclk_in);
    #2;
    chk({4'h0, cur}, 8'h04);
    count100();
    chk(hits[2], 8'h32);
    chk(hits[0], 8'h64);
    i_host.pins(1'b1, 1'b0, 1'b1);
    repeat (6) @(posedge mclk_in);
    #2;
    chk({4'h0, cur}, 8'h00);
  endtask
  task automatic t_wipe();
    setup(3'h3, 1'b1, 1'b0, 4'hf, 4'hf);
    i_host.pins(1'b1, 1'b1, 1'b0);
    repeat (4) @(posedge mclk_in);
    i_host.pins(1'b1, 1'b1, 1'b1);
    repeat (6) @(posedge mclk_in);
    #2;
    chk({4'h0, cur}, 8'h00);
    count100();
    chk(hits[0], 8'h64);
  endtask
  initial begin
    nrst_in = 1'b0;
    repeat (10) @(posedge mclk_in);
    #1;
    nrst_in = 1'b1;
    repeat (4) @(posedge mclk_in);
    count100();
    chk(hits[2], 8'h64);
    t_duty();
    t_gblank();
    t_pin();
    t_compat();
    t_cursor();
    t_wipe();
    print_verdict();
  end
endmodule // display_blank_dim_control_tb_top
`default_nettype wire
